// file: hdl/prq_defs.svh
// Offsets, field positions and fixed contents of the partition region query table.
`ifndef PRQ_DEFS_SVH
`define PRQ_DEFS_SVH

// Query location indices; the bus byte address of a location is four times its index.
`define PRQ_IDX_REGION_LEN 12'h12E
`define PRQ_IDX_PART_COUNT 12'h130
`define PRQ_IDX_OP_LIMITS 12'h132
`define PRQ_IDX_OPS_PROG 12'h133
`define PRQ_IDX_OPS_ERASE 12'h134
`define PRQ_IDX_ERASE_TYPES 12'h135
`define PRQ_IDX_BLK1_GEOM 12'h136
`define PRQ_IDX_ENDURANCE 12'h13A
`define PRQ_IDX_CELL_BITS 12'h13C
`define PRQ_IDX_ACCESS_MODES 12'h13D
`define PRQ_IDX_PROG_LAYOUT 12'h13E
`define PRQ_IDX_LAST 12'h143

// Number of query locations held by each multi-location field.
`define PRQ_LEN_REGION_LEN 12'h002
`define PRQ_LEN_PART_COUNT 12'h002
`define PRQ_LEN_BLK1_GEOM 12'h004
`define PRQ_LEN_ENDURANCE 12'h002
`define PRQ_LEN_PROG_LAYOUT 12'h006

// Field positions inside the fields.
`define PRQ_NIB_PROG_LSB 0
`define PRQ_NIB_ERASE_LSB 4
`define PRQ_GEOM_COUNT_LSB 0
`define PRQ_GEOM_SIZE_LSB 16
`define PRQ_CELL_BITS_LSB 0
`define PRQ_CELL_ECC_BIT 4
`define PRQ_MODE_PAGE_RD_BIT 0
`define PRQ_MODE_SYNC_RD_BIT 1
`define PRQ_MODE_SYNC_WR_BIT 2
`define PRQ_LAYOUT_ALIGN_LSB 0
`define PRQ_LAYOUT_LEGACY_LO_BIT 15
`define PRQ_LAYOUT_VALID_LSB 16
`define PRQ_LAYOUT_INVALID_LSB 32
`define PRQ_LAYOUT_LEGACY_HI_BIT 47

// Fixed contents for a uniformly blocked part.
`define PRQ_VAL_REGION_LEN 16'h0014
`define PRQ_VAL_PART_COUNT 16'h0001
`define PRQ_VAL_OP_LIMITS 8'h11
`define PRQ_VAL_OPS_PROG 8'h00
`define PRQ_VAL_OPS_ERASE 8'h00
`define PRQ_VAL_ERASE_TYPES 8'h01
`define PRQ_VAL_BLK1_GEOM 32'h020001FF
`define PRQ_VAL_ENDURANCE 16'h0064
`define PRQ_VAL_CELL_BITS 8'h02
`define PRQ_VAL_ACCESS_MODES 8'h03
`define PRQ_VAL_PROG_LAYOUT 48'h000000008000

// Bus address width and response codes.
`define PRQ_ADDR_W 12
`define PRQ_RESP_OKAY 2'h0
`define PRQ_RESP_SLVERR 2'h2

`endif

// file: hdl/prq_pkg.sv
// Types shared by the partition region query table.
`include "prq_defs.svh"

package prq_pkg;

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [`PRQ_ADDR_W-1:0] waddr;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } prq_state_t;

   typedef struct packed {
      logic hit;
      logic [7:0] data;
   } prq_lookup_t;

endpackage

// file: hdl/prq_query_table.sv
// AXI4-Lite read-only query table describing the first partition region.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "prq_defs.svh"

module prq_query_table
   import prq_pkg::*;
#(
   parameter logic [15:0] REGION_LEN = `PRQ_VAL_REGION_LEN,
   parameter logic [15:0] PART_COUNT = `PRQ_VAL_PART_COUNT,
   parameter logic [7:0] OP_LIMITS = `PRQ_VAL_OP_LIMITS,
   parameter logic [7:0] OPS_PROG = `PRQ_VAL_OPS_PROG,
   parameter logic [7:0] OPS_ERASE = `PRQ_VAL_OPS_ERASE,
   parameter logic [7:0] ERASE_TYPES = `PRQ_VAL_ERASE_TYPES,
   parameter logic [31:0] BLK1_GEOM = `PRQ_VAL_BLK1_GEOM,
   parameter logic [15:0] ENDURANCE = `PRQ_VAL_ENDURANCE,
   parameter logic [7:0] CELL_BITS = `PRQ_VAL_CELL_BITS,
   parameter logic [7:0] ACCESS_MODES = `PRQ_VAL_ACCESS_MODES,
   parameter logic [47:0] PROG_LAYOUT = `PRQ_VAL_PROG_LAYOUT
) (
   input wire logic aclk, // System clock.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic [`PRQ_ADDR_W-1:0] s_axi_awaddr, // Write byte address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address taken.
   input wire logic [31:0] s_axi_wdata, // Write data, discarded.
   input wire logic [3:0] s_axi_wstrb, // Write strobes, discarded.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data taken.
   output logic [1:0] s_axi_bresp, // Write response code.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response accepted.
   input wire logic [`PRQ_ADDR_W-1:0] s_axi_araddr, // Read byte address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address taken.
   output logic [31:0] s_axi_rdata, // Read data, query byte in bits 7:0.
   output logic [1:0] s_axi_rresp, // Read response code.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready // Read data accepted.
);

   prq_state_t q;
   prq_state_t n;

   // Number of query locations held in the array and the width of a slot number.
   localparam int ROM_DEPTH = int'(`PRQ_IDX_LAST - `PRQ_IDX_REGION_LEN) + 1;
   localparam int SLOT_W = $clog2(ROM_DEPTH);

   logic [7:0] rom [ROM_DEPTH];

   // Picks one byte of a multi-location field; the lowest location holds the low byte.
   function automatic logic [7:0] field_byte(input logic [47:0] val, input logic [2:0] pos);
      logic [47:0] sh;
      sh = val >> {pos, 3'h0};
      return sh[7:0];
   endfunction

   // True when a location index falls inside a field of the given base and length.
   function automatic logic in_field(input logic [`PRQ_ADDR_W-1:0] idx,
                                     input logic [`PRQ_ADDR_W-1:0] base,
                                     input logic [`PRQ_ADDR_W-1:0] len);
      return (idx >= base) && (idx < base + len);
   endfunction

   // Fixed content of one slot of the array, worked out from the content parameters.
   function automatic logic [7:0] rom_byte(input int unsigned slot);
      prq_lookup_t r;
      logic [`PRQ_ADDR_W-1:0] idx;
      logic [`PRQ_ADDR_W-1:0] off;
      r.hit = 1'b1;
      r.data = 8'h00;
      idx = 12'(`PRQ_IDX_REGION_LEN + slot);
      off = 12'h000;
      if (in_field(idx, `PRQ_IDX_REGION_LEN, `PRQ_LEN_REGION_LEN)) begin
         off = idx - `PRQ_IDX_REGION_LEN;
         r.data = field_byte({32'h0, REGION_LEN}, off[2:0]);
      end else if (in_field(idx, `PRQ_IDX_PART_COUNT, `PRQ_LEN_PART_COUNT)) begin
         off = idx - `PRQ_IDX_PART_COUNT;
         r.data = field_byte({32'h0, PART_COUNT}, off[2:0]);
      end else if (idx == `PRQ_IDX_OP_LIMITS) begin
         r.data = OP_LIMITS;
      end else if (idx == `PRQ_IDX_OPS_PROG) begin
         r.data = OPS_PROG;
      end else if (idx == `PRQ_IDX_OPS_ERASE) begin
         r.data = OPS_ERASE;
      end else if (idx == `PRQ_IDX_ERASE_TYPES) begin
         r.data = ERASE_TYPES;
      end else if (in_field(idx, `PRQ_IDX_BLK1_GEOM, `PRQ_LEN_BLK1_GEOM)) begin
         off = idx - `PRQ_IDX_BLK1_GEOM;
         r.data = field_byte({16'h0, BLK1_GEOM}, off[2:0]);
      end else if (in_field(idx, `PRQ_IDX_ENDURANCE, `PRQ_LEN_ENDURANCE)) begin
         off = idx - `PRQ_IDX_ENDURANCE;
         r.data = field_byte({32'h0, ENDURANCE}, off[2:0]);
      end else if (idx == `PRQ_IDX_CELL_BITS) begin
         // Reserved bits 7:5 always read as zero.
         r.data = {3'h0, CELL_BITS[4:0]};
      end else if (idx == `PRQ_IDX_ACCESS_MODES) begin
         r.data = {5'h00, ACCESS_MODES[2:0]};
      end else if (in_field(idx, `PRQ_IDX_PROG_LAYOUT, `PRQ_LEN_PROG_LAYOUT)) begin
         off = idx - `PRQ_IDX_PROG_LAYOUT;
         // The legacy flags are reported as stored; it is the host that ignores the sizes.
         r.data = field_byte(PROG_LAYOUT, off[2:0]);
      end else begin
         r.hit = 1'b0;
      end
      return r.data;
   endfunction

   // Every entry is a constant, so the array costs no flip-flops.
   for (genvar i = 0; i < ROM_DEPTH; i++) begin : g_rom
      assign rom[i] = rom_byte(i);
   end

   // True for an aligned byte address that lands on a query location.
   function automatic logic is_mapped(input logic [`PRQ_ADDR_W-1:0] addr);
      logic [`PRQ_ADDR_W-1:0] idx;
      idx = {2'h0, addr[`PRQ_ADDR_W-1:2]};
      return (addr[1:0] == 2'h0) && (idx >= `PRQ_IDX_REGION_LEN) && (idx <= `PRQ_IDX_LAST);
   endfunction

   // Slot of a byte address in the array; an unmapped address falls back to slot zero.
   function automatic logic [SLOT_W-1:0] slot_of(input logic [`PRQ_ADDR_W-1:0] addr);
      logic [`PRQ_ADDR_W-1:0] pos;
      pos = {2'h0, addr[`PRQ_ADDR_W-1:2]} - `PRQ_IDX_REGION_LEN;
      return is_mapped(addr) ? pos[SLOT_W-1:0] : '0;
   endfunction

   // Decodes a byte address into its response flag and query byte; shared by both paths.
   function automatic prq_lookup_t lookup(input logic [`PRQ_ADDR_W-1:0] addr);
      prq_lookup_t r;
      r.hit = is_mapped(addr);
      r.data = r.hit ? rom[slot_of(addr)] : 8'h00;
      return r;
   endfunction

   prq_lookup_t wr_lk;
   prq_lookup_t rd_lk;

   always_comb begin
      wr_lk = lookup(q.waddr);
      rd_lk = lookup(s_axi_araddr);
      n = q;
      // Write path: address and data may arrive in either order or together.
      if (s_axi_awvalid && q.awready) begin
         n.aw_got = 1'b1;
         n.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         n.w_got = 1'b1;
      end
      if (q.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (n.aw_got && n.w_got && !n.bvalid) begin
         // Data never reaches storage; a mapped location just answers OKAY.
         wr_lk = lookup(n.waddr);
         n.bvalid = 1'b1;
         n.bresp = wr_lk.hit ? `PRQ_RESP_OKAY : `PRQ_RESP_SLVERR;
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
      end
      // Each channel is closed while its half is held or a response is pending.
      n.awready = !n.aw_got && !n.bvalid;
      n.wready = !n.w_got && !n.bvalid;
      // Read path: one read in flight, answered the cycle after the address is taken.
      if (q.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q.arready) begin
         n.rvalid = 1'b1;
         n.rdata = {24'h000000, rd_lk.data};
         n.rresp = rd_lk.hit ? `PRQ_RESP_OKAY : `PRQ_RESP_SLVERR;
      end
      n.arready = !n.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '{awready: 1'b1, wready: 1'b1, aw_got: 1'b0, w_got: 1'b0,
                waddr: 12'h000, bvalid: 1'b0, bresp: 2'h0, arready: 1'b1,
                rvalid: 1'b0, rdata: 32'h00000000, rresp: 2'h0};
      end else begin
         q <= n;
      end
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;

endmodule

// file: verif/prq_query_table_chk.sv
// Bus timing and content assertions for the query table.
`timescale 1ns/1ps
`include "prq_defs.svh"
module prq_query_table_chk (
   input wire logic aclk, // Clock.
   input wire logic aresetn, // Reset, active low.
   input wire logic [`PRQ_ADDR_W-1:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   input wire logic s_axi_awready, // Write address taken.
   input wire logic s_axi_wvalid, // Write data valid.
   input wire logic s_axi_wready, // Write data taken.
   input wire logic [1:0] s_axi_bresp, // Write response.
   input wire logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response accepted.
   input wire logic [`PRQ_ADDR_W-1:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   input wire logic s_axi_arready, // Read address taken.
   input wire logic [31:0] s_axi_rdata, // Read data.
   input wire logic [1:0] s_axi_rresp, // Read response.
   input wire logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready // Read data accepted.
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_ar;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_aw_w;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   AST_RD_ANSWER: assert property (s_ar |=> s_axi_rvalid) else $error("read answer late");
   AST_WR_ANSWER: assert property (s_aw_w |=> s_axi_bvalid && !s_axi_awready)
      else $error("write answer late");
   AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
   AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped");
   AST_AR_REFUSED: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
   AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_RD_TYPES: assert property (s_ar ##0 s_axi_araddr == (`PRQ_IDX_ERASE_TYPES << 2)
      |=> s_axi_rdata[7:0] == `PRQ_VAL_ERASE_TYPES) else $error("region type count wrong");
   AST_RD_MISALIGN: assert property (s_ar ##0 s_axi_araddr[1:0] != 2'h0 |=>
      s_axi_rresp == `PRQ_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("misaligned ok");
   AST_WR_OKAY: assert property (s_aw_w ##0 s_axi_awaddr == (`PRQ_IDX_CELL_BITS << 2) |=>
      s_axi_bresp == `PRQ_RESP_OKAY) else $error("mapped write refused");
endmodule
bind prq_query_table prq_query_table_chk i_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// file: verif/prq_host.sv
// Host side model: an AXI4-Lite master reading query bytes.
`timescale 1ns/1ps
module prq_host (
   input wire logic aclk, // Clock.
   output logic [11:0] awaddr, // Write address.
   output logic awvalid, // Write address valid.
   input wire logic awready, // Write address taken.
   output logic [31:0] wdata, // Write data.
   output logic [3:0] wstrb, // Write strobes.
   output logic wvalid, // Write data valid.
   input wire logic wready, // Write data taken.
   input wire logic [1:0] bresp, // Write response.
   input wire logic bvalid, // Write response valid.
   output logic bready, // Write response accepted.
   output logic [11:0] araddr, // Read address.
   output logic arvalid, // Read address valid.
   input wire logic arready, // Read address taken.
   input wire logic [31:0] rdata, // Read data.
   input wire logic [1:0] rresp, // Read response.
   input wire logic rvalid, // Read data valid.
   output logic rready // Read data accepted.
);
   int tmo = 0;
   initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
   // Ready may come late, so answers are also seen held by the table.
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      repeat (1 + $urandom % 3) @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'($urandom);
      bready <= 1'($urandom);
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (!(bvalid && bready) && n < 50) bready <= 1'b1;
      end while (!(bvalid && bready) && n < 50);
      r = bresp;
      bready <= 1'b0;
      if (n >= 50) begin
         tmo++;
         $display("[FAIL] %0t write answer timed out", $time);
      end
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      repeat (1 + $urandom % 3) @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'($urandom);
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
         if (!(rvalid && rready) && n < 50) rready <= 1'b1;
      end while (!(rvalid && rready) && n < 50);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n >= 50) begin
         tmo++;
         $display("[FAIL] %0t read answer timed out", $time);
      end
   endtask
endmodule

// file: verif/test_partition_region_query_table.sv
// Self-checking bench for the query table.
`timescale 1ns/1ps
`include "prq_defs.svh"
module test_partition_region_query_table;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   int failures = 0;
   int check_count = 0;
   int mdl[$];
   logic [175:0] img = {`PRQ_VAL_PROG_LAYOUT, `PRQ_VAL_ACCESS_MODES, `PRQ_VAL_CELL_BITS,
      `PRQ_VAL_ENDURANCE, `PRQ_VAL_BLK1_GEOM, `PRQ_VAL_ERASE_TYPES, `PRQ_VAL_OPS_ERASE,
      `PRQ_VAL_OPS_PROG, `PRQ_VAL_OP_LIMITS, `PRQ_VAL_PART_COUNT, `PRQ_VAL_REGION_LEN};
   logic [11:0] bad[4] = '{12'h4B4, 12'h510, 12'h000, 12'hFFC};
   prq_query_table i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   prq_host i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   initial begin
      forever #4 aclk = ~aclk;
   end
   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t data %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t response %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      failures += i_host.tmo;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #400000;
      $display("[FAIL] %0t run limit reached", $time);
      failures++;
      complete_run();
   end
   initial begin
      logic [31:0] d;
      logic [1:0] r, rw;
      logic [11:0] a;
      void'($urandom(47727));
      for (int k = 0; k < 22; k++) mdl.push_back(int'(img[8*k+:8]));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      // Each location is written with junk while it is read; a second pass follows a reset.
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 22; k++) begin
            a = 12'((k + 'h12E) * 4);
            fork
               i_host.wr(a, $urandom, rw);
               i_host.rd(a, d, r);
            join
            chk_resp(rw, `PRQ_RESP_OKAY);
            chk_resp(r, `PRQ_RESP_OKAY);
            chk_data(d, 32'(mdl[k]));
            // A read after the write has finished shows that the write changed nothing.
            i_host.rd(a, d, r);
            chk_resp(r, `PRQ_RESP_OKAY);
            chk_data(d, 32'(mdl[k]));
         end
         aresetn <= 1'b0;
         repeat (2) @(posedge aclk);
         aresetn <= 1'b1;
      end
      for (int k = 0; k < 8; k++) begin
         a = (k < 4) ? bad[k] : 12'(($urandom % 22 + 'h12E) * 4 + 1 + $urandom % 3);
         i_host.wr(a, $urandom, rw);
         chk_resp(rw, `PRQ_RESP_SLVERR);
         i_host.rd(a, d, r);
         chk_resp(r, `PRQ_RESP_SLVERR);
         chk_data(d, 32'h0);
      end
      complete_run();
   end
endmodule
